// [hdl/sac_bitclk.sv]
// Half bit period tick source: divided oscillator or synchronised RC clock.
`timescale 1ns/1ps
`default_nettype none
module sac_bitclk (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [1:0] clk_sel,
    input  wire logic       rc_clk,
    output logic            half_tick
);
    logic [3:0] div_cnt_r;
    logic [3:0] div_last;
    logic [2:0] rc_sync_r;

    always_comb begin
        case (clk_sel)
            sac_pkg::CLK_DIV2:  div_last = 4'(sac_pkg::TOSC_DIV2 / 2 - 1);
            sac_pkg::CLK_DIV8:  div_last = 4'(sac_pkg::TOSC_DIV8 / 2 - 1);
            sac_pkg::CLK_DIV32: div_last = 4'(sac_pkg::TOSC_DIV32 / 2 - 1);
            default:            div_last = 4'h0;
        endcase
    end

    // The RC clock runs on its own; each of its edges is half a bit period.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_sync_r <= 3'h0;
        end else if (ce) begin
            rc_sync_r <= {rc_sync_r[1:0], rc_clk};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 4'h0;
        end else if (ce) begin
            if (!run || div_cnt_r == div_last) begin
                div_cnt_r <= 4'h0;
            end else begin
                div_cnt_r <= div_cnt_r + 4'h1;
            end
        end
    end

    always_comb begin
        if (clk_sel == sac_pkg::CLK_RC) begin
            half_tick = run && (rc_sync_r[2] != rc_sync_r[1]);
        end else begin
            half_tick = run && (div_cnt_r == div_last);
        end
    end
endmodule
`default_nettype wire

// [hdl/sac_pkg.sv]
// Shared constants and types for the converter sequencer.
package sac_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CHAN_N = 4;

    // Register byte offsets on the bus.
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_RESULT = 8'h04;
    localparam logic [7:0] OFF_FLAG   = 8'h08;
    localparam logic [7:0] OFF_IRQEN  = 8'h0c;
    localparam logic [7:0] OFF_PORT   = 8'h10;
    localparam logic [7:0] OFF_PINCFG = 8'h14;

    // Control register zero field positions.
    localparam int unsigned CLKSEL_HI = 7;
    localparam int unsigned CLKSEL_LO = 6;
    localparam int unsigned CHSEL_HI  = 4;
    localparam int unsigned CHSEL_LO  = 3;
    localparam int unsigned GO_BIT    = 2;
    localparam int unsigned PWR_BIT   = 0;

    // Reset values.
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [3:0] PINCFG_RST = 4'hf;

    // Clock select codes.
    localparam logic [1:0] CLK_DIV2  = 2'b00;
    localparam logic [1:0] CLK_DIV8  = 2'b01;
    localparam logic [1:0] CLK_DIV32 = 2'b10;
    localparam logic [1:0] CLK_RC    = 2'b11;

    // Oscillator periods per bit period for each divided selection.
    localparam int unsigned TOSC_DIV2  = 2;
    localparam int unsigned TOSC_DIV8  = 8;
    localparam int unsigned TOSC_DIV32 = 32;

    // Timing in half bit periods; one pclk equals one oscillator period.
    localparam int unsigned SAMPLE_HALVES = 1;
    localparam int unsigned CONV_HALVES   = 19;
    localparam int unsigned HOLD_HALVES   = 4;
    localparam logic [4:0]  CONV_LAST     = 5'(CONV_HALVES - SAMPLE_HALVES - 1);
    localparam logic [4:0]  BIT_HALVES    = 5'(2 * DATA_W);
    localparam logic [4:0]  HOLD_LAST     = 5'(HOLD_HALVES - 1);

    // One instruction cycle spent before an RC-clocked conversion.
    localparam int unsigned INSTR_NS   = 200;
    localparam int unsigned PCLK_NS    = 50;
    localparam logic [4:0]  INSTR_LAST = 5'((INSTR_NS + PCLK_NS - 1) / PCLK_NS - 1);

    typedef enum {
        ST_ACQ,
        ST_WAIT,
        ST_SAMPLE,
        ST_CONV,
        ST_HOLD
    } sac_state_e;

    typedef struct packed {
        logic [1:0] clk_sel;
        logic [1:0] ch_sel;
        logic       go;
        logic       pwr_on;
    } sac_ctrl_s;
endpackage

// [hdl/sac_sar.sv]
// Successive approximation register, most significant bit first.
`timescale 1ns/1ps
`default_nettype none
module sac_sar #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    input  wire logic             load,
    input  wire logic             step,
    input  wire logic             comp_hi,
    output logic [WIDTH-1:0]      trial
);
    logic [WIDTH-1:0] probe_r;

    initial begin
        if (WIDTH < 2 || WIDTH > 16) begin
            $error("sac_sar: WIDTH out of range");
        end
    end

    // A kept bit stays set; the probe then moves to the next lower bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trial   <= '0;
            probe_r <= '0;
        end else if (ce) begin
            if (load) begin
                trial   <= {1'b1, {(WIDTH-1){1'b0}}};
                probe_r <= {1'b1, {(WIDTH-1){1'b0}}};
            end else if (step) begin
                trial   <= (comp_hi ? trial : (trial & ~probe_r)) | (probe_r >> 1);
                probe_r <= probe_r >> 1;
            end
        end
    end
endmodule
`default_nettype wire

// [hdl/sac_top.sv]
// Conversion sequencer with its APB register file.
`timescale 1ns/1ps
`default_nettype none
module sac_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rc_clk,
    input  wire logic        sleep_mode,
    input  wire logic        comp_hi,
    input  wire logic [3:0]  port_pins,
    output logic [7:0]       dac_code,
    output logic [1:0]       mux_channel,
    output logic             sample_connect,
    output logic             analog_enable,
    output logic             conv_irq
);
    localparam int unsigned W = sac_pkg::DATA_W;

    sac_pkg::sac_ctrl_s   ctrl_r;
    sac_pkg::sac_state_e  state_r;
    logic [W-1:0]         result_r;
    logic                 done_flag_r;
    logic                 irq_en_r;
    logic [3:0]           analog_mask_r;
    logic                 powered_down_r;
    logic [4:0]           cnt_r;
    logic [1:0]           comp_sync_r;
    logic [3:0]           pin_s1_r;
    logic [3:0]           pin_s2_r;

    logic                 wr_en;
    logic                 rd_setup;
    logic                 wr_ctrl;
    logic                 sw_go;
    logic                 busy;
    logic                 abort;
    logic                 sleep_abort;
    logic                 half_tick;
    logic                 run_clk;
    logic                 sar_load;
    logic                 sar_step;
    logic                 complete;
    logic [W-1:0]         trial;
    logic [31:0]          rd_data;
    logic                 rd_err;

    initial begin
        if (W != 8) begin
            $error("sac_top: data width must be 8");
        end
    end

    // Bus decode: a setup cycle prepares the answer, the access cycle
    // then completes with pready high.
    assign rd_setup = psel && !penable;
    assign wr_en    = psel && penable && pready && pwrite && pstrb[0];
    assign wr_ctrl  = wr_en && paddr == sac_pkg::OFF_CTRL;
    assign sw_go    = pwdata[sac_pkg::GO_BIT];

    assign busy = state_r == sac_pkg::ST_WAIT
               || state_r == sac_pkg::ST_SAMPLE
               || state_r == sac_pkg::ST_CONV;

    assign abort       = busy && wr_ctrl && !sw_go;
    assign sleep_abort = busy && sleep_mode && ctrl_r.clk_sel != sac_pkg::CLK_RC;

    assign complete = state_r == sac_pkg::ST_CONV && half_tick
                   && cnt_r == sac_pkg::CONV_LAST;
    assign sar_load = state_r == sac_pkg::ST_SAMPLE && half_tick;
    assign sar_step = state_r == sac_pkg::ST_CONV && half_tick
                   && cnt_r[0] && cnt_r < sac_pkg::BIT_HALVES;

    assign run_clk = state_r != sac_pkg::ST_ACQ && state_r != sac_pkg::ST_WAIT;

    sac_bitclk u_bitclk (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .run       (run_clk),
        .clk_sel   (ctrl_r.clk_sel),
        .rc_clk    (rc_clk),
        .half_tick (half_tick)
    );

    sac_sar #(
        .WIDTH (W)
    ) u_sar (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .load    (sar_load),
        .step    (sar_step),
        .comp_hi (comp_sync_r[1]),
        .trial   (trial)
    );

    // Comparator and port pins come from the analog side and are synchronised.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_sync_r <= 2'h0;
            pin_s1_r    <= 4'h0;
            pin_s2_r    <= 4'h0;
        end else if (ce) begin
            comp_sync_r <= {comp_sync_r[0], comp_hi};
            pin_s1_r    <= port_pins;
            pin_s2_r    <= pin_s1_r;
        end
    end

    // Sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= sac_pkg::ST_ACQ;
            cnt_r   <= 5'h0;
        end else if (ce) begin
            if (abort || sleep_abort) begin
                state_r <= sac_pkg::ST_HOLD;
                cnt_r   <= 5'h0;
            end else begin
                case (state_r)
                    sac_pkg::ST_ACQ: begin
                        cnt_r <= 5'h0;
                        if (wr_ctrl && sw_go && ctrl_r.pwr_on
                                && pwdata[sac_pkg::PWR_BIT]) begin
                            if (pwdata[sac_pkg::CLKSEL_HI:sac_pkg::CLKSEL_LO]
                                    == sac_pkg::CLK_RC) begin
                                state_r <= sac_pkg::ST_WAIT;
                            end else begin
                                state_r <= sac_pkg::ST_SAMPLE;
                            end
                        end
                    end
                    sac_pkg::ST_WAIT: begin
                        if (cnt_r == sac_pkg::INSTR_LAST) begin
                            state_r <= sac_pkg::ST_SAMPLE;
                            cnt_r   <= 5'h0;
                        end else begin
                            cnt_r <= cnt_r + 5'h1;
                        end
                    end
                    sac_pkg::ST_SAMPLE: begin
                        if (half_tick) begin
                            state_r <= sac_pkg::ST_CONV;
                            cnt_r   <= 5'h0;
                        end
                    end
                    sac_pkg::ST_CONV: begin
                        if (half_tick) begin
                            if (complete) begin
                                state_r <= sac_pkg::ST_HOLD;
                                cnt_r   <= 5'h0;
                            end else begin
                                cnt_r <= cnt_r + 5'h1;
                            end
                        end
                    end
                    sac_pkg::ST_HOLD: begin
                        if (half_tick) begin
                            if (cnt_r == sac_pkg::HOLD_LAST) begin
                                state_r <= sac_pkg::ST_ACQ;
                                cnt_r   <= 5'h0;
                            end else begin
                                cnt_r <= cnt_r + 5'h1;
                            end
                        end
                    end
                    default: begin
                        state_r <= sac_pkg::ST_ACQ;
                        cnt_r   <= 5'h0;
                    end
                endcase
            end
        end
    end

    // Control register zero; hardware clears the start bit on completion.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= sac_pkg::sac_ctrl_s'(6'h00);
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_r.clk_sel <= pwdata[sac_pkg::CLKSEL_HI:sac_pkg::CLKSEL_LO];
                ctrl_r.ch_sel  <= pwdata[sac_pkg::CHSEL_HI:sac_pkg::CHSEL_LO];
                ctrl_r.pwr_on  <= pwdata[sac_pkg::PWR_BIT];
            end
            if (complete || sleep_abort) begin
                ctrl_r.go <= 1'b0;
            end else if (wr_ctrl) begin
                // A start during the hold-off is refused, so the bit never stands idle.
                ctrl_r.go <= sw_go && ctrl_r.pwr_on && pwdata[sac_pkg::PWR_BIT]
                          && state_r != sac_pkg::ST_HOLD;
            end
        end
    end

    // Result: loaded only on completion or by software, never by reset.
    always_ff @(posedge pclk) begin
        if (ce) begin
            if (complete) begin
                result_r <= trial;
            end else if (wr_en && paddr == sac_pkg::OFF_RESULT) begin
                result_r <= pwdata[W-1:0];
            end
        end
    end

    // Done flag: a completion in the same cycle as a software clear wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag_r <= 1'b0;
        end else if (ce) begin
            if (complete) begin
                done_flag_r <= 1'b1;
            end else if (wr_en && paddr == sac_pkg::OFF_FLAG && !pwdata[0]) begin
                done_flag_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_r      <= 1'b0;
            analog_mask_r <= sac_pkg::PINCFG_RST;
        end else if (ce) begin
            if (wr_en && paddr == sac_pkg::OFF_IRQEN) begin
                irq_en_r <= pwdata[0];
            end
            if (wr_en && paddr == sac_pkg::OFF_PINCFG) begin
                analog_mask_r <= pwdata[3:0];
            end
        end
    end

    // Power-down in sleep leaves the power bit set; waking restores power.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powered_down_r <= 1'b0;
        end else if (ce) begin
            if (!sleep_mode) begin
                powered_down_r <= 1'b0;
            end else if (sleep_abort) begin
                powered_down_r <= 1'b1;
            end else if (complete && !irq_en_r) begin
                powered_down_r <= 1'b1;
            end
        end
    end

    // Read mux.
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        case (paddr)
            sac_pkg::OFF_CTRL: begin
                rd_data[sac_pkg::CLKSEL_HI:sac_pkg::CLKSEL_LO] = ctrl_r.clk_sel;
                rd_data[sac_pkg::CHSEL_HI:sac_pkg::CHSEL_LO]   = ctrl_r.ch_sel;
                rd_data[sac_pkg::GO_BIT]                       = ctrl_r.go;
                rd_data[sac_pkg::PWR_BIT]                      = ctrl_r.pwr_on;
            end
            sac_pkg::OFF_RESULT: rd_data[W-1:0] = result_r;
            sac_pkg::OFF_FLAG:   rd_data[0]     = done_flag_r;
            sac_pkg::OFF_IRQEN:  rd_data[0]     = irq_en_r;
            sac_pkg::OFF_PORT:   rd_data[3:0]   = pin_s2_r & ~analog_mask_r;
            sac_pkg::OFF_PINCFG: rd_data[3:0]   = analog_mask_r;
            default:             rd_err         = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= rd_setup;
            if (rd_setup) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_data;
                pslverr <= rd_err;
            end
        end
    end

    // Analog side. The mux follows the channel field regardless of pin
    // direction, and the sample node is only connected, never reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_code       <= 8'h00;
            mux_channel    <= 2'h0;
            sample_connect <= 1'b0;
            analog_enable  <= 1'b0;
            conv_irq       <= 1'b0;
        end else if (ce) begin
            dac_code       <= trial;
            mux_channel    <= ctrl_r.ch_sel;
            sample_connect <= ctrl_r.pwr_on && !powered_down_r
                           && (state_r == sac_pkg::ST_ACQ
                               || state_r == sac_pkg::ST_WAIT
                               || state_r == sac_pkg::ST_SAMPLE);
            analog_enable  <= ctrl_r.pwr_on && !powered_down_r;
            conv_irq       <= done_flag_r && irq_en_r;
        end
    end
endmodule
`default_nettype wire

// [sim/sac_analog_model.sv]
// Behavioural sample-and-hold and comparator on the converter's analog side.
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model (
    input  wire logic        pclk,
    input  wire logic        analog_enable,
    input  wire logic        sample_connect,
    input  wire logic [1:0]  mux_channel,
    input  wire logic [7:0]  dac_code,
    input  wire logic [31:0] levels,
    output logic             comp_hi
);
    logic [7:0] hold_v = 8'h00;
    // The held level follows the pin only while the switch is closed and is never cleared.
    always @(posedge pclk) if (sample_connect) hold_v <= levels[8*mux_channel +: 8];
    always_comb comp_hi = analog_enable & (hold_v >= dac_code);
endmodule
`default_nettype wire

// [sim/sac_top_properties.sv]
// Port-level assertions for the converter sequencer.
`timescale 1ns/1ps
`default_nettype none
module sac_top_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sample_connect,
    input wire logic        analog_enable,
    input wire logic        conv_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_next; psel && !penable |=> pready; endproperty
    a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
    property p_ready_once; pready |=> !pready; endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready held too long");
    property p_unmapped; psel && !penable && paddr > 8'h14 |=> pslverr && pready; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
    property p_rdata_held; !(psel && !penable) |=> $stable(prdata) && $stable(pslverr); endproperty
    a_rdata_held: assert property (p_rdata_held) else $error("read data moved");
    property p_reset_quiet; $rose(presetn) |-> !analog_enable && !sample_connect && !conv_irq;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
    property p_unpowered; !analog_enable [*2] |-> !sample_connect; endproperty
    a_unpowered: assert property (p_unpowered) else $error("switch closed while off");
    property p_hold_off; $fell(sample_connect) && analog_enable |=> !sample_connect [*4];
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("switch closed too soon");
    property p_irq_clear; $fell(conv_irq) |-> $past(psel && penable && pready && pwrite, 2);
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("request dropped unasked");
endmodule
`default_nettype wire

// [sim/sac_top_tb.sv]
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
`default_nettype none
module sac_top_tb;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [3:0]  s;
    } sac_row_s;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rc_clk;
    logic        sleep_mode, comp_hi, sample_connect, analog_enable, conv_irq;
    logic [7:0]  paddr, dac_code;
    logic [1:0]  mux_channel;
    logic [3:0]  pstrb, port_pins;
    logic [31:0] pwdata, prdata, levels, rdv;
    int          fails, check_count, n, h;
    sac_row_s    rows [14];

    always #25 pclk = ~pclk;
    initial begin
        rc_clk = 1'b0;
        #1234;
        forever #2000 rc_clk = ~rc_clk;
    end

    sac_top dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rc_clk(rc_clk), .sleep_mode(sleep_mode),
        .comp_hi(comp_hi), .port_pins(port_pins), .dac_code(dac_code),
        .mux_channel(mux_channel), .sample_connect(sample_connect),
        .analog_enable(analog_enable), .conv_irq(conv_irq));
    sac_analog_model ana_u (.pclk(pclk), .analog_enable(analog_enable),
        .sample_connect(sample_connect), .mux_channel(mux_channel), .dac_code(dac_code),
        .levels(levels), .comp_hi(comp_hi));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) begin
            fails++;
            complete_run();
        end
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'h0);
        check(rdv, e);
    endtask
    // Counts clock edges until the signal shows the wanted level.
    task automatic await(ref logic sig, input logic v, input int lim);
        n = 0;
        while (sig !== v) begin
            @(posedge pclk);
            n++;
            if (n > lim) begin
                fails++;
                complete_run();
            end
        end
    endtask

    initial begin
        {pclk, presetn, psel, penable, pwrite, sleep_mode} = 6'h0;
        {paddr, pwdata, pstrb} = '0;
        port_pins = 4'ha;
        // Code 00 runs far below the minimum bit period here, so its channel sits at full scale.
        levels = 32'h01b74cff;
        fails = 0;
        check_count = 0;
        rows = '{'{1'b0, 8'h00, 32'h0, 4'h0}, '{1'b0, 8'h08, 32'h0, 4'h0},
                 '{1'b0, 8'h0c, 32'h0, 4'h0}, '{1'b0, 8'h14, 32'hf, 4'h0},
                 '{1'b0, 8'h10, 32'h0, 4'h0}, '{1'b1, 8'h04, 32'h5a, 4'hf},
                 '{1'b0, 8'h04, 32'h5a, 4'h0}, '{1'b1, 8'h0c, 32'h1, 4'he},
                 '{1'b0, 8'h0c, 32'h0, 4'h0}, '{1'b1, 8'h0c, 32'h1, 4'hf},
                 '{1'b0, 8'h0c, 32'h1, 4'h0}, '{1'b1, 8'h14, 32'h2, 4'hf},
                 '{1'b0, 8'h10, 32'h8, 4'h0}, '{1'b0, 8'h18, 32'h0, 4'h0}};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            if (rows[i].w)
                apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
            else
                rd(rows[i].a, rows[i].d);
        end
        check(pslverr, 1'b1);
        $display("test registers done");
        for (int c = 0; c < 3; c++) begin
            h = 1 << (2 * c);
            wr(8'h00, {c[1:0], 1'b0, c[1:0], 3'b001});
            repeat (40) @(posedge pclk);
            wr(8'h00, {c[1:0], 1'b0, c[1:0], 3'b101});
            await(sample_connect, 1'b0, 40);
            await(sample_connect, 1'b1, 1000);
            check(32'(n >= 22 * h - 3 && n <= 22 * h + 3), 32'h1);
            rd(8'h04, {24'h0, levels[8*c +: 8]});
            rd(8'h08, 32'h1);
            rd(8'h00, {24'h0, c[1:0], 1'b0, c[1:0], 3'b001});
            check(mux_channel, c[1:0]);
            check(conv_irq, 1'b1);
            wr(8'h08, 32'h0);
            @(posedge pclk);
            check(conv_irq, 1'b0);
        end
        $display("test conversions done");
        wr(8'h00, 32'h49);
        repeat (40) @(posedge pclk);
        wr(8'h00, 32'h4d);
        repeat (20) @(posedge pclk);
        wr(8'h00, 32'h49);
        await(sample_connect, 1'b1, 200);
        check(32'(n >= 12 && n <= 18), 32'h1);
        rd(8'h04, 32'hb7);
        rd(8'h08, 32'h0);
        rd(8'h00, 32'h49);
        $display("test abort done");
        wr(8'h00, 32'h91);
        repeat (40) @(posedge pclk);
        wr(8'h00, 32'h95);
        repeat (30) @(posedge pclk);
        sleep_mode <= 1'b1;
        repeat (10) @(posedge pclk);
        check(analog_enable, 1'b0);
        rd(8'h00, 32'h91);
        rd(8'h08, 32'h0);
        sleep_mode <= 1'b0;
        repeat (5) @(posedge pclk);
        check(analog_enable, 1'b1);
        $display("test divided sleep done");
        wr(8'h0c, 32'h0);
        wr(8'h00, 32'hd9);
        // The hold-off left by the sleep abort now runs on the slow RC clock.
        await(sample_connect, 1'b1, 300);
        repeat (40) @(posedge pclk);
        wr(8'h00, 32'hdd);
        sleep_mode <= 1'b1;
        await(analog_enable, 1'b0, 3000);
        rd(8'h04, 32'h01);
        rd(8'h00, 32'hd9);
        check(conv_irq, 1'b0);
        sleep_mode <= 1'b0;
        wr(8'h08, 32'h0);
        $display("test rc sleep done");
        wr(8'h00, 32'h0);
        repeat (4) @(posedge pclk);
        wr(8'h00, 32'h05);
        rd(8'h00, 32'h01);
        repeat (40) @(posedge pclk);
        wr(8'h00, 32'h05);
        repeat (8) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(analog_enable, 1'b0);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h01);
        $display("test reset done");
        complete_run();
    end
endmodule

bind sac_top sac_top_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_connect(sample_connect), .analog_enable(analog_enable),
    .conv_irq(conv_irq));
`default_nettype wire
